// [hw/pkh_buf2.sv]
`timescale 1ns/1ps
module pkh_buf2 #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Filling and draining sides
  pkh_strm_if.snk up,
  pkh_strm_if.src dn
);

  logic [W-1:0] out_q;
  logic [W-1:0] skid_q;
  logic out_v_q;
  logic skid_v_q;

  wire pop = out_v_q && dn.ready;
  wire push = up.valid && !skid_v_q;
  wire load_out = !out_v_q || pop;

  assign up.ready = !skid_v_q;
  assign dn.valid = out_v_q;
  assign dn.data = out_q;

  // Skid slot only fills while the output slot is stalled
  always_ff @(posedge clk) begin
    if (reset) begin
      out_v_q <= 1'b0;
      skid_v_q <= 1'b0;
    end else if (load_out) begin
      out_v_q <= skid_v_q || push;
      skid_v_q <= 1'b0;
    end else if (push) begin
      skid_v_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (load_out) begin
      out_q <= skid_v_q ? skid_q : up.data;
    end
    if (!load_out && push) begin
      skid_q <= up.data;
    end
  end

endmodule : pkh_buf2

// [hw/pkh_pkg.sv]
package pkh_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int CFG_AW = 5;
  localparam logic [CFG_AW-1:0] A_LINE = 5'h1c;
  localparam logic [CFG_AW-1:0] A_STN = 5'h1d;
  localparam logic [CFG_AW-1:0] A_FRM = 5'h1e;
  localparam logic [CFG_AW-1:0] A_QUE = 5'h1f;

  localparam logic [7:0] RST_LINE = 8'h00;
  localparam logic [7:0] RST_STN = 8'h00;
  localparam logic [7:1] RST_FRM = 7'h24;
  localparam logic [7:0] RST_QUE = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;

  localparam int B_MAN = 7;
  localparam int LEN_HI = 6;
  localparam int B_FMT = 7;
  localparam int PRE_HI = 6;
  localparam int PRE_LO = 5;
  localparam int B_WHT = 4;
  localparam int B_CRC = 3;
  localparam int FLT_HI = 2;
  localparam int FLT_LO = 1;
  localparam int B_KEEP = 7;
  localparam int B_RDIR = 6;

  // ----------------------------------------------------------------
  // Framing constants
  // ----------------------------------------------------------------
  localparam logic [7:0] PREAMBLE_BYTE = 8'haa;
  localparam logic [8:0] PN9_SEED = 9'h1ff;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [7:0] ADDR_ZERO = 8'h00;
  localparam logic [7:0] ADDR_ALL = 8'hff;

  typedef enum logic [1:0] {
    F_OFF = 2'b00,
    F_NODE = 2'b01,
    F_ZERO = 2'b10,
    F_BCAST = 2'b11
  } pkh_filt_e;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_PRE = 3'b001,
    T_LEN = 3'b010,
    T_ADR = 3'b011,
    T_PAY = 3'b100,
    T_CRC1 = 3'b101,
    T_CRC2 = 3'b110
  } pkh_tx_e;

  typedef enum logic [2:0] {
    R_IDLE = 3'b000,
    R_LEN = 3'b001,
    R_ADR = 3'b010,
    R_PAY = 3'b011,
    R_CRC1 = 3'b100,
    R_CRC2 = 3'b101,
    R_DROP = 3'b110
  } pkh_rx_e;

  // ----------------------------------------------------------------
  // Coding helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] pkh_crc_byte(logic [15:0] c, logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : pkh_crc_byte

  function automatic logic [8:0] pkh_pn9_adv(logic [8:0] s);
    logic [8:0] r;
    r = s;
    for (int i = 0; i < 8; i++) begin
      r = {r[0] ^ r[5], r[8:1]};
    end
    return r;
  endfunction : pkh_pn9_adv

  function automatic logic [7:0] pkh_man_enc(logic [3:0] n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 4; i++) begin
      r[2*i+1] = n[i];
      r[2*i] = ~n[i];
    end
    return r;
  endfunction : pkh_man_enc

  function automatic logic [3:0] pkh_man_dec(logic [7:0] b);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 4; i++) begin
      r[i] = b[2*i+1];
    end
    return r;
  endfunction : pkh_man_dec

endpackage : pkh_pkg

// [hw/pkh_strm_if.sv]
`timescale 1ns/1ps
interface pkh_strm_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : pkh_strm_if

// [hw/pkh_top.sv]
// What this block does
// - Line coding bit 7 of register 0x1c turns on symbol coding for received bytes and for sent bytes after the preamble.
// - The 7-bit body size is the exact length when fixed, the receive ceiling when variable.
// - An 8-bit station identifier, reset to zero, is the reference for address filtering.
// - Bit 7 of register 0x1e picks fixed (0, reset) or variable (1) frame length.
// - The 2-bit lead-in code sends 1 to 4 preamble bytes, 3 bytes after reset.
// - Bit 4 of register 0x1e turns on scrambling and descrambling, off after reset.
// - Bit 3 of register 0x1e turns on check code generation and checking, on after reset.
// - Station match mode: off, own id only, plus 0x00, plus 0x00 and 0xff; others are dropped.
// - Bit 0 of register 0x1e reads back whether the last received frame passed its check.
// - Unless bit 7 of register 0x1f is set, a failed check clears the FIFO.
// - Bit 6 of register 0x1f sets standby FIFO access: 0 write, 1 read.
`timescale 1ns/1ps
module pkh_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [pkh_pkg::CFG_AW-1:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Transmit request and payload
  input wire logic tx_start,
  input wire logic [6:0] tx_len,
  input wire logic [7:0] tx_addr,
  input wire logic tx_in_valid,
  input wire logic [7:0] tx_in_data,
  output logic tx_in_ready,
  output logic tx_busy,
  // Transmit byte stream
  output logic tx_out_valid,
  output logic [7:0] tx_out_data,
  input wire logic tx_out_ready,
  // Receive byte stream
  input wire logic rx_sof,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // FIFO side
  output logic fifo_wr,
  output logic [7:0] fifo_wdata,
  output logic fifo_clear,
  output logic fifo_standby_read,
  output logic rx_done
);
  import pkh_pkg::*;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] line_q;
  logic [7:0] stn_q;
  logic [7:1] frm_q;
  logic [7:0] que_q;
  logic [7:0] rdata_q;
  logic crc_ok_q;
  logic stby_rd_q;

  wire sel_line = cfg_addr == A_LINE;
  wire sel_stn = cfg_addr == A_STN;
  wire sel_frm = cfg_addr == A_FRM;
  wire sel_que = cfg_addr == A_QUE;
  wire line_code = line_q[B_MAN];
  wire [6:0] body_size = line_q[LEN_HI:0];
  wire var_len = frm_q[B_FMT];
  wire [1:0] pre_code = frm_q[PRE_HI:PRE_LO];
  wire scramble = frm_q[B_WHT];
  wire check_on = frm_q[B_CRC];
  wire pkh_filt_e filt = pkh_filt_e'(frm_q[FLT_HI:FLT_LO]);
  wire keep_on_fail = que_q[B_KEEP];
  wire [7:0] rd_mux = sel_line ? line_q : sel_stn ? stn_q :
                      sel_frm ? {frm_q, crc_ok_q} : sel_que ? que_q : RD_NONE;

  always_ff @(posedge clk) begin
    if (reset) begin
      line_q <= RST_LINE;
      stn_q <= RST_STN;
      frm_q <= RST_FRM;
      que_q <= RST_QUE;
    end else if (cfg_wr) begin
      if (sel_line) line_q <= cfg_wdata;
      if (sel_stn) stn_q <= cfg_wdata;
      if (sel_frm) frm_q <= cfg_wdata[7:1];
      if (sel_que) que_q <= cfg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= RD_NONE;
      stby_rd_q <= 1'b0;
    end else begin
      if (cfg_rd) rdata_q <= rd_mux;
      stby_rd_q <= que_q[B_RDIR];
    end
  end

  // ----------------------------------------------------------------
  // Transmit framer
  // ----------------------------------------------------------------
  pkh_strm_if #(.W(8)) buf_in ();
  pkh_strm_if #(.W(8)) buf_out ();

  pkh_tx_e tx_st_q;
  pkh_tx_e tx_st_d;
  logic [6:0] tx_cnt_q;
  logic [6:0] tx_len_q;
  logic [7:0] tx_adr_q;
  logic [15:0] tx_crc_q;
  logic [8:0] tx_pn_q;
  logic tx_half_q;
  logic [7:0] hold_q;
  logic hold_v_q;
  logic rdy_q;
  logic busy_q;

  wire tx_coded = tx_st_q != T_PRE;
  wire tx_two = line_code && tx_coded;
  wire [7:0] tx_raw = (tx_st_q == T_PRE) ? PREAMBLE_BYTE :
                      (tx_st_q == T_LEN) ? {1'b0, tx_len_q} :
                      (tx_st_q == T_ADR) ? tx_adr_q :
                      (tx_st_q == T_CRC1) ? tx_crc_q[15:8] :
                      (tx_st_q == T_CRC2) ? tx_crc_q[7:0] : hold_q;
  wire [7:0] tx_wht = (scramble && tx_coded) ? (tx_raw ^ tx_pn_q[7:0]) : tx_raw;
  wire [7:0] tx_enc = tx_half_q ? pkh_man_enc(tx_wht[3:0]) : pkh_man_enc(tx_wht[7:4]);
  wire [7:0] tx_byte = tx_two ? tx_enc : tx_wht;
  wire tx_emit = (tx_st_q != T_IDLE) && ((tx_st_q != T_PAY) || hold_v_q);
  wire tx_push = tx_emit && buf_in.ready;
  wire tx_adv = tx_push && (!tx_two || tx_half_q);
  wire [6:0] tx_end = (tx_st_q == T_PRE) ? 7'(pre_code) : 7'(tx_len_q - 7'h01);
  wire tx_last = tx_cnt_q == tx_end;
  wire tx_hdr = (tx_st_q == T_LEN) || (tx_st_q == T_ADR) || (tx_st_q == T_PAY);
  wire hold_take = tx_in_valid && rdy_q;
  wire hold_use = tx_adv && (tx_st_q == T_PAY);
  wire hold_v_d = hold_take || (hold_v_q && !hold_use);
  wire pkh_tx_e t_after_pay = check_on ? T_CRC1 : T_IDLE;
  wire pkh_tx_e t_after_adr = (tx_len_q != 7'h00) ? T_PAY : t_after_pay;
  wire pkh_tx_e t_after_len = (filt != F_OFF) ? T_ADR : t_after_adr;
  wire pkh_tx_e t_after_pre = var_len ? T_LEN : t_after_len;

  assign buf_in.valid = tx_emit;
  assign buf_in.data = tx_byte;
  assign buf_out.ready = tx_out_ready;

  always_comb begin
    tx_st_d = tx_st_q;
    unique case (tx_st_q)
      T_IDLE: if (tx_start) tx_st_d = T_PRE;
      T_PRE: if (tx_adv && tx_last) tx_st_d = t_after_pre;
      T_LEN: if (tx_adv) tx_st_d = t_after_len;
      T_ADR: if (tx_adv) tx_st_d = t_after_adr;
      T_PAY: if (tx_adv && tx_last) tx_st_d = t_after_pay;
      T_CRC1: if (tx_adv) tx_st_d = T_CRC2;
      T_CRC2: if (tx_adv) tx_st_d = T_IDLE;
      default: tx_st_d = T_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_st_q <= T_IDLE;
      tx_cnt_q <= 7'h00;
      tx_half_q <= 1'b0;
      hold_v_q <= 1'b0;
      rdy_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      hold_v_q <= hold_v_d;
      rdy_q <= (tx_st_d == T_PAY) && !hold_v_d;
      busy_q <= tx_st_d != T_IDLE;
      if (tx_push && tx_two) tx_half_q <= !tx_half_q;
      if (tx_st_q == T_IDLE) tx_cnt_q <= 7'h00;
      else if (tx_adv) tx_cnt_q <= (tx_st_q != tx_st_d) ? 7'h00 : 7'(tx_cnt_q + 7'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (tx_st_q == T_IDLE && tx_start) begin
      tx_len_q <= var_len ? tx_len : body_size;
      tx_adr_q <= tx_addr;
      tx_crc_q <= CRC_INIT;
      tx_pn_q <= PN9_SEED;
    end else if (tx_adv) begin
      if (tx_hdr) tx_crc_q <= pkh_crc_byte(tx_crc_q, tx_raw);
      if (tx_coded) tx_pn_q <= pkh_pn9_adv(tx_pn_q);
    end
    if (hold_take) hold_q <= tx_in_data;
  end

  pkh_buf2 #(.W(8)) u_buf (
    .clk(clk),
    .reset(reset),
    .up(buf_in.snk),
    .dn(buf_out.src)
  );

  // ----------------------------------------------------------------
  // Receive deframer
  // ----------------------------------------------------------------
  pkh_rx_e rx_st_q;
  pkh_rx_e rx_st_d;
  logic [6:0] rx_cnt_q;
  logic [6:0] rx_len_q;
  logic [15:0] rx_crc_q;
  logic [8:0] rx_pn_q;
  logic rx_half_q;
  logic [7:0] rx_hi_q;
  logic [7:0] rx_chk_q;
  logic fwr_q;
  logic [7:0] fdat_q;
  logic fclr_q;
  logic done_q;

  wire rx_act = (rx_st_q != R_IDLE) && (rx_st_q != R_DROP);
  wire rx_byte_v = rx_valid && rx_act && (!line_code || rx_half_q);
  wire [7:0] rx_dec = {pkh_man_dec(rx_hi_q), pkh_man_dec(rx_data)};
  wire [7:0] rx_cat = line_code ? rx_dec : rx_data;
  wire [7:0] rx_b = scramble ? (rx_cat ^ rx_pn_q[7:0]) : rx_cat;
  wire adr_ok = (filt == F_OFF) || (rx_b == stn_q) ||
                ((filt != F_NODE) && (rx_b == ADDR_ZERO)) ||
                ((filt == F_BCAST) && (rx_b == ADDR_ALL));
  wire [6:0] len_now = (rx_st_q == R_LEN) ? rx_b[6:0] : rx_len_q;
  wire rx_last = rx_cnt_q == 7'(rx_len_q - 7'h01);
  wire rx_pass = (rx_st_q != R_CRC2) || ({rx_chk_q, rx_b} == rx_crc_q);
  wire rx_fin = rx_byte_v && !rx_sof && (rx_st_d == R_IDLE);
  wire rx_hdr = (rx_st_q == R_LEN) || (rx_st_q == R_ADR) || (rx_st_q == R_PAY);
  wire pkh_rx_e r_after_pay = check_on ? R_CRC1 : R_IDLE;
  wire pkh_rx_e r_after_adr = (len_now != 7'h00) ? R_PAY : r_after_pay;
  wire pkh_rx_e r_after_len = (filt != F_OFF) ? R_ADR : r_after_adr;
  wire pkh_rx_e r_first = var_len ? R_LEN : (filt != F_OFF) ? R_ADR :
                          (body_size != 7'h00) ? R_PAY : r_after_pay;

  always_comb begin
    rx_st_d = rx_st_q;
    if (rx_sof) begin
      rx_st_d = r_first;
    end else if (rx_byte_v) begin
      unique case (rx_st_q)
        R_LEN: rx_st_d = (rx_b[6:0] > body_size) ? R_DROP : r_after_len;
        R_ADR: rx_st_d = adr_ok ? r_after_adr : R_DROP;
        R_PAY: if (rx_last) rx_st_d = r_after_pay;
        R_CRC1: rx_st_d = R_CRC2;
        R_CRC2: rx_st_d = R_IDLE;
        default: rx_st_d = R_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_st_q <= R_IDLE;
      rx_half_q <= 1'b0;
      fwr_q <= 1'b0;
      fclr_q <= 1'b0;
      done_q <= 1'b0;
      crc_ok_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      if (rx_sof) rx_half_q <= 1'b0;
      else if (rx_valid && rx_act && line_code) rx_half_q <= !rx_half_q;
      fwr_q <= rx_byte_v && !rx_sof && (rx_st_q == R_PAY);
      fclr_q <= rx_fin && !rx_pass && !keep_on_fail;
      done_q <= rx_fin;
      if (rx_fin) crc_ok_q <= rx_pass;
    end
  end

  always_ff @(posedge clk) begin
    if (rx_sof) begin
      rx_len_q <= body_size;
      rx_cnt_q <= 7'h00;
      rx_crc_q <= CRC_INIT;
      rx_pn_q <= PN9_SEED;
    end else if (rx_byte_v) begin
      if (rx_st_q == R_LEN) rx_len_q <= rx_b[6:0];
      if (rx_st_q == R_PAY) rx_cnt_q <= 7'(rx_cnt_q + 7'h01);
      if (rx_hdr) rx_crc_q <= pkh_crc_byte(rx_crc_q, rx_b);
      rx_pn_q <= pkh_pn9_adv(rx_pn_q);
    end
    if (rx_valid && !rx_half_q) rx_hi_q <= rx_data;
    if (rx_byte_v && rx_st_q == R_CRC1) rx_chk_q <= rx_b;
    fdat_q <= rx_b;
  end

  assign cfg_rdata = rdata_q;
  assign tx_in_ready = rdy_q;
  assign tx_busy = busy_q;
  assign tx_out_valid = buf_out.valid;
  assign tx_out_data = buf_out.data;
  assign fifo_wr = fwr_q;
  assign fifo_wdata = fdat_q;
  assign fifo_clear = fclr_q;
  assign fifo_standby_read = stby_rd_q;
  assign rx_done = done_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [2:0] pre_seen_q;
  logic [6:0] pay_seen_q;

  always_ff @(posedge clk) begin
    if (reset || (tx_st_q == T_IDLE)) begin
      pre_seen_q <= 3'h0;
      pay_seen_q <= 7'h00;
    end else if (tx_adv) begin
      if (tx_st_q == T_PRE) pre_seen_q <= 3'(pre_seen_q + 3'h1);
      if (tx_st_q == T_PAY) pay_seen_q <= 7'(pay_seen_q + 7'h01);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_man_pairs: assert property (
    (tx_push && tx_two) |-> (buf_in.data[7] != buf_in.data[6]))
    else $error("Coded half byte is not a valid symbol pair");
  chk_plain_bytes: assert property (
    (tx_push && !line_code && !scramble) |-> (buf_in.data == tx_raw))
    else $error("Byte altered while coding and scrambling are off");
  chk_scramble_on: assert property (
    (tx_push && scramble && !tx_two && tx_coded) |-> (buf_in.data == (tx_raw ^ tx_pn_q[7:0])))
    else $error("Scrambled byte does not match sequence");
  chk_fixed_len: assert property (
    ($fell(tx_st_q == T_PAY) && !var_len) |-> (pay_seen_q == body_size))
    else $error("Fixed frame body length differs from setting");
  chk_rx_len_cap: assert property (
    (rx_byte_v && !rx_sof && rx_st_q == R_LEN && rx_b[6:0] > body_size) |=> rx_st_q == R_DROP)
    else $error("Overlong received frame not dropped");
  chk_station_hit: assert property (
    (rx_byte_v && !rx_sof && rx_st_q == R_ADR && rx_b == stn_q) |=> rx_st_q != R_DROP)
    else $error("Own station identifier rejected");
  chk_var_header: assert property (
    (rx_sof && var_len) |=> (rx_st_q == R_LEN))
    else $error("Variable frame did not start with length");
  chk_pre_count: assert property (
    $fell(tx_st_q == T_PRE) |-> (pre_seen_q == 3'(pre_code) + 3'h1))
    else $error("Preamble byte count wrong");
  chk_check_bytes: assert property (
    (tx_adv && tx_st_q == T_PAY && tx_last && check_on) |=> ##1 (tx_st_q == T_CRC1) or
    (tx_st_q == T_CRC1))
    else $error("Check code not sent after body");
  chk_addr_reject: assert property (
    (rx_byte_v && !rx_sof && rx_st_q == R_ADR && filt != F_OFF && rx_b != stn_q &&
     rx_b != ADDR_ZERO && rx_b != ADDR_ALL) |=> rx_st_q == R_DROP)
    else $error("Foreign address accepted");
  chk_flag_result: assert property (
    rx_fin |=> (crc_ok_q == $past(rx_pass)))
    else $error("Check flag does not hold last result");
  chk_auto_clear: assert property (
    (rx_fin && !rx_pass) |=> (fifo_clear != $past(keep_on_fail)))
    else $error("FIFO clear does not follow keep setting");
  chk_standby_dir: assert property (
    $changed(que_q[B_RDIR]) |=> (fifo_standby_read == $past(que_q[B_RDIR])))
    else $error("Standby direction output not following register");
  chk_drop_silent: assert property (
    (rx_st_q == R_DROP) |=> (!fifo_wr && $stable(crc_ok_q)))
    else $error("Dropped frame delivered data or changed flag");

endmodule : pkh_top

// [sim/pkh_sink.sv]
`timescale 1ns/1ps
module pkh_sink (
  // Clock
  input wire logic clk,
  // Stall request from the bench
  input wire logic stall,
  // Coded byte stream
  input wire logic valid,
  input wire logic [7:0] data,
  output logic ready
);
  logic [7:0] got[$];
  logic [1:0] ph = 2'b00;

  // ----------------------------------------------------------------
  // Accepts one cycle in four while stalling
  // ----------------------------------------------------------------
  initial ready = 1'b0;
  always @(negedge clk) begin
    ph <= ph + 2'b01;
    ready <= !stall || (ph == 2'b11);
  end
  always @(posedge clk) begin
    if (valid && ready) got.push_back(data);
  end
endmodule : pkh_sink

// [sim/pkh_top_tb.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module pkh_top_tb;
  import pkh_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [CFG_AW-1:0] cfg_addr = 5'h00;
  logic cfg_wr = 1'b0, cfg_rd = 1'b0, tx_start = 1'b0, tx_in_valid = 1'b1;
  logic [7:0] cfg_wdata = 8'h00, cfg_rdata, tx_addr = 8'h00, tx_in_data, tx_out_data;
  logic [6:0] tx_len = 7'h00, bsz = 7'h00;
  logic tx_in_ready, tx_busy, tx_out_valid, tx_out_ready, stall = 1'b0, acc;
  logic rx_sof = 1'b0, rx_valid = 1'b0, fifo_wr, fifo_clear, fifo_standby_read, rx_done;
  logic [7:0] rx_data = 8'h00, fifo_wdata;
  logic man = 1'b0, fmt = 1'b0, wht = 1'b0, crcon = 1'b1, keep = 1'b0;
  logic [1:0] pre = 2'b10, flt = 2'b00;
  logic [7:0] pay [0:7] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
  logic [7:0] av [0:3] = '{8'h5a, 8'h00, 8'hff, 8'h33};
  logic [7:0] fr[$], ex[$], fq[$];
  logic [2:0] pidx = 3'h0;
  int n_errors = 0, cmp_count = 0, n_done = 0, n_clr = 0;

  always #5 clk = ~clk;
  assign tx_in_data = pay[pidx];

  pkh_top i_dut (.clk(clk), .reset(reset), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .tx_start(tx_start),
    .tx_len(tx_len), .tx_addr(tx_addr), .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
    .tx_in_ready(tx_in_ready), .tx_busy(tx_busy), .tx_out_valid(tx_out_valid),
    .tx_out_data(tx_out_data), .tx_out_ready(tx_out_ready), .rx_sof(rx_sof),
    .rx_valid(rx_valid), .rx_data(rx_data), .fifo_wr(fifo_wr), .fifo_wdata(fifo_wdata),
    .fifo_clear(fifo_clear), .fifo_standby_read(fifo_standby_read), .rx_done(rx_done));
  pkh_sink i_sink (.clk(clk), .stall(stall), .valid(tx_out_valid), .data(tx_out_data),
    .ready(tx_out_ready));

  // ----------------------------------------------------------------
  // Payload feed and FIFO side monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (tx_in_valid && tx_in_ready) pidx <= pidx + 3'h1;
    if (!reset && fifo_wr) fq.push_back(fifo_wdata);
    if (!reset && fifo_clear) n_clr++;
    if (!reset && rx_done) n_done++;
  end

  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction : crc_step

  function automatic logic [7:0] mc(logic [3:0] n);
    logic [7:0] r;
    for (int i = 0; i < 4; i++) r[2*i+:2] = {n[i], ~n[i]};
    return r;
  endfunction : mc

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk); cfg_addr = a; cfg_wdata = d; cfg_wr = 1'b1;
    @(negedge clk); cfg_wr = 1'b0;
  endtask : wr

  task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
    @(negedge clk); cfg_addr = a; cfg_rd = 1'b1;
    @(negedge clk); cfg_rd = 1'b0;
    `CHK(cfg_rdata, e)
  endtask : chk_rd

  task automatic setup();
    wr(A_LINE, {man, bsz});
    wr(A_FRM, {fmt, pre, wht, crcon, flt, 1'b0});
    wr(A_QUE, {keep, 7'h00});
  endtask : setup

  // Frame bytes after the preamble, before any coding
  task automatic build(input logic [6:0] n, input logic [7:0] ad);
    logic [15:0] c;
    c = 16'hffff;
    fr = {};
    if (fmt) fr.push_back({1'b0, n});
    if (flt != 2'b00) fr.push_back(ad);
    for (int i = 0; i < n; i++) fr.push_back(pay[i]);
    foreach (fr[i]) c = crc_step(c, fr[i]);
    if (crcon) begin fr.push_back(c[15:8]); fr.push_back(c[7:0]); end
  endtask : build

  task automatic send(input logic [6:0] n, input logic [7:0] ad);
    logic [8:0] s;
    build(n, ad);
    ex = {};
    s = 9'h1ff;
    repeat (int'(pre) + 1) ex.push_back(8'haa);
    foreach (fr[i]) begin
      if (man) begin ex.push_back(mc(fr[i][7:4])); ex.push_back(mc(fr[i][3:0])); end
      else ex.push_back(fr[i]);
    end
    for (int i = int'(pre) + 1; wht && i < ex.size(); i++) begin
      ex[i] ^= s[7:0];
      repeat (8) s = {s[0] ^ s[5], s[8:1]};
    end
    i_sink.got = {};
    @(negedge clk); pidx = 3'h0; tx_start = 1'b1; tx_len = n; tx_addr = ad;
    @(negedge clk); tx_start = 1'b0;
    for (int i = 0; i < 500 && tx_busy !== 1'b0; i++) @(negedge clk);
    repeat (20) @(negedge clk);
    `CHK(i_sink.got.size(), ex.size())
    foreach (ex[i]) `CHK(i_sink.got[i], ex[i])
  endtask : send

  // Sent bytes are scrambled first, then split into two coded halves
  task automatic recv(input logic bad);
    logic [8:0] s;
    logic [7:0] v, b;
    fq = {};
    s = 9'h1ff;
    @(negedge clk); rx_sof = 1'b1;
    @(negedge clk); rx_sof = 1'b0;
    foreach (fr[i]) begin
      v = wht ? fr[i] ^ s[7:0] : fr[i];
      repeat (8) s = {s[0] ^ s[5], s[8:1]};
      for (int h = 0; h < (man ? 2 : 1); h++) begin
        b = !man ? v : (h == 0) ? mc(v[7:4]) : mc(v[3:0]);
        rx_valid = 1'b1;
        rx_data = (bad && i == fr.size() - 1) ? ~b : b;
        @(negedge clk);
      end
    end
    rx_valid = 1'b0;
    repeat (4) @(negedge clk);
  endtask : recv

  task automatic give_verdict();
    $display("Compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    chk_rd(A_LINE, 8'h00);
    chk_rd(A_STN, 8'h00);
    chk_rd(A_FRM, 8'h48);
    chk_rd(A_QUE, 8'h00);
    chk_rd(5'h03, 8'h00);
    wr(A_FRM, 8'hff);
    chk_rd(A_FRM, 8'hfe);
    wr(A_STN, 8'h5a);
    chk_rd(A_STN, 8'h5a);
    wr(A_QUE, 8'h40);
    chk_rd(A_QUE, 8'h40);
    `CHK(fifo_standby_read, 1'b1)
    bsz = 7'd3;
    crcon = 1'b0;
    for (int p = 0; p < 4; p++) begin
      pre = p[1:0];
      stall = (p == 3);
      setup();
      send(7'd3, 8'h00);
    end
    pre = 2'b10;
    fmt = 1'b1; crcon = 1'b1; flt = 2'b01; setup();
    send(7'd5, 8'h5a);
    fmt = 1'b0; flt = 2'b00; wht = 1'b1; setup();
    send(7'd3, 8'h00);
    wht = 1'b0; man = 1'b1; setup();
    send(7'd3, 8'h00);
    man = 1'b0; setup();
    // Receive: good frame, failed frame, failed frame with clearing off
    build(7'd3, 8'h00);
    n_done = 0; n_clr = 0;
    recv(1'b0);
    `CHK(fq.size(), 3)
    foreach (fq[i]) `CHK(fq[i], pay[i])
    chk_rd(A_FRM, 8'h49);
    recv(1'b1);
    `CHK(n_clr, 1)
    chk_rd(A_FRM, 8'h48);
    keep = 1'b1; setup();
    recv(1'b1);
    `CHK(n_clr, 1)
    `CHK(n_done, 3)
    keep = 1'b0;
    for (int m = 0; m < 4; m++) for (int k = 0; k < 4; k++) begin
      flt = m[1:0]; setup(); build(7'd3, av[k]);
      n_done = 0;
      recv(1'b0);
      acc = m == 0 || av[k] == 8'h5a || (m >= 2 && av[k] == 8'h00) || (m == 3 && av[k] == 8'hff);
      `CHK(n_done, int'(acc))
      `CHK(fq.size(), acc ? 3 : 0)
    end
    flt = 2'b01; setup();
    build(7'd3, 8'h5a);
    recv(1'b0);
    build(7'd3, 8'h33);
    recv(1'b1);
    chk_rd(A_FRM, 8'h4b);
    // Variable length receive above and at the ceiling
    fmt = 1'b1; flt = 2'b00; setup();
    build(7'd4, 8'h00);
    n_done = 0;
    recv(1'b0);
    `CHK(n_done, 0)
    build(7'd3, 8'h00);
    recv(1'b0);
    `CHK(n_done, 1)
    // Receive with line decoding and descrambling together
    fmt = 1'b0; man = 1'b1; wht = 1'b1; setup();
    build(7'd3, 8'h00);
    n_done = 0;
    recv(1'b0);
    `CHK(n_done, 1)
    `CHK(fq.size(), 3)
    foreach (fq[i]) `CHK(fq[i], pay[i])
    give_verdict();
  end
endmodule : pkh_top_tb
